//--- verilog/erase_seq_consts.vh
`ifndef ERASE_SEQ_CONSTS_VH
`define ERASE_SEQ_CONSTS_VH

// =====================================================
// Opcodes
`define OP_SET_WRITE_LATCH 8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_READ_STATUS 8'h05
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE 8'hC7

// =====================================================
// Status fields
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1

// =====================================================
// Address fields
`define BLK_IDX_LSB 16
`define BLK_IDX_MSB 18
`define ADDR_BYTES 3

// =====================================================
// Timing
`define CLK_PERIOD_NS 50
`define CHIP_ERASE_TIME_MS 4000
`define BLOCK_ERASE_TIME_MS 1000

`endif

//--- verilog/erase_array_model.v
`include "erase_seq_consts.vh"

// =====================================================
// Erase engine: per-block erased flags, timed busy
module erase_array_model #(
  parameter NUM_BLOCKS = 8,
  parameter CHIP_CYCLES = 80000000,
  parameter BLOCK_CYCLES = 20000000
) (
  input wire sys_clk,
  input wire rst_b,
  input wire startBlock,
  input wire startChip,
  input wire [2:0] blockIdx,
  input wire [NUM_BLOCKS-1:0] protectMask,
  output reg busy_q,
  output reg [NUM_BLOCKS-1:0] erased_q,
  output reg doneP_q
);
  reg [31:0] cnt_q;
  integer i;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      cnt_q <= 32'h0000_0000;
      erased_q <= {NUM_BLOCKS{1'b0}};
      doneP_q <= 1'b0;
    end else begin
      doneP_q <= 1'b0;
      if (busy_q) begin
        if (cnt_q <= 32'h0000_0001) begin
          busy_q <= 1'b0;
          doneP_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 32'h0000_0001;
        end
      end else if (startBlock) begin
        busy_q <= 1'b1;
        cnt_q <= BLOCK_CYCLES;
        if (!protectMask[blockIdx]) begin
          erased_q[blockIdx] <= 1'b1; // R1 R3
        end
      end else if (startChip) begin
        busy_q <= 1'b1;
        cnt_q <= CHIP_CYCLES; // R9
        for (i = 0; i < NUM_BLOCKS; i = i + 1) begin
          if (!protectMask[i]) begin
            erased_q[i] <= 1'b1; // R8
          end
        end
      end
    end
  end
endmodule // erase_array_model

//--- verilog/block_and_chip_erase_sequencer.v
`include "erase_seq_consts.vh"

// Operation
// R1 - A block erase sets every byte of the addressed 64K block to ones.
// R2 - The host must send a set-write-latch command before each erase, else the erase is dropped.
// R3 - A block locked by write protection is not erased.
// R4 - Any address inside a block selects that block.
// R5 - During a block erase only the status read is answered.
// R6 - Status bit 0 is one while an erase runs and zero after.
// R7 - The write latch clears when a block erase ends.
// R8 - A chip erase erases all unprotected blocks and leaves protected ones.
// R9 - The chip erase is self-timed with a nominal four seconds.
// R10 - During a chip erase only the status read is answered.
// R11 - The write latch clears when a chip erase ends.
// R12 - The block index is address bits 18 to 16.
module block_and_chip_erase_sequencer #(
  parameter NUM_BLOCKS = 8,
  parameter CHIP_CYCLES = `CHIP_ERASE_TIME_MS * (1000000 / `CLK_PERIOD_NS),
  parameter BLOCK_CYCLES = `BLOCK_ERASE_TIME_MS * (1000000 / `CLK_PERIOD_NS)
) (
  input wire sys_clk,
  input wire rst_b,
  input wire spiSck,
  input wire spiCs_b,
  input wire spiMosi,
  input wire [NUM_BLOCKS-1:0] protectMask,
  output reg spiMiso_q,
  output reg spiMisoOe_q,
  output reg eraseBusy_q,
  output reg writeLatch_q,
  output reg [NUM_BLOCKS-1:0] blockErased_q
);
  // =====================================================
  // Input synchronisers
  reg [1:0] sckSync_q;
  reg [1:0] csSync_q;
  reg [1:0] mosiSync_q;
  reg sckPrev_q;
  reg csPrev_q;
  reg [NUM_BLOCKS-1:0] protSync1_q;
  reg [NUM_BLOCKS-1:0] protSync2_q;
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      protSync1_q <= {NUM_BLOCKS{1'b0}};
      protSync2_q <= {NUM_BLOCKS{1'b0}};
      sckSync_q <= 2'b00;
      csSync_q <= 2'b11;
      mosiSync_q <= 2'b00;
      sckPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
    end else begin
      sckSync_q <= {sckSync_q[0], spiSck};
      csSync_q <= {csSync_q[0], spiCs_b};
      mosiSync_q <= {mosiSync_q[0], spiMosi};
      sckPrev_q <= sckSync_q[1];
      csPrev_q <= csSync_q[1];
      protSync1_q <= protectMask;
      protSync2_q <= protSync1_q;
    end
  end
  wire sckRise = sckSync_q[1] & ~sckPrev_q;
  wire sckFall = ~sckSync_q[1] & sckPrev_q;
  wire csLow = ~csSync_q[1];
  wire csRiseEv = csSync_q[1] & ~csPrev_q;

  // =====================================================
  // Frame states
  localparam [3:0] S_OP = 4'b0001;
  localparam [3:0] S_ADDR = 4'b0010;
  localparam [3:0] S_STAT = 4'b0100;
  localparam [3:0] S_IGN = 4'b1000;
  localparam integer ADDR_LAST = `ADDR_BYTES * 8 - 1;
  localparam integer IDX_FIRST = ADDR_LAST - `BLK_IDX_MSB;
  localparam integer IDX_LAST = ADDR_LAST - `BLK_IDX_LSB;

  reg [3:0] state_q;
  reg [7:0] shift_q;
  reg [4:0] bitCnt_q;
  reg [7:0] op_q;
  reg [2:0] blkIdx_q;
  reg addrDone_q;
  reg [7:0] statShift_q;
  reg startBlock_q;
  reg startChip_q;
  wire engBusy;
  wire engDone;
  wire [NUM_BLOCKS-1:0] engErased;
  wire [7:0] shiftNext = {shift_q[6:0], mosiSync_q[1]};

  function isCmd;
    input [7:0] o;
    input [7:0] code;
    begin
      isCmd = (o == code);
    end
  endfunction

  wire [7:0] statusByte = {6'b00_0000, writeLatch_q, engBusy}; // R6

  // =====================================================
  // Command decoder
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= S_OP;
      shift_q <= 8'h00;
      bitCnt_q <= 5'h00;
      op_q <= 8'h00;
      blkIdx_q <= 3'h0;
      addrDone_q <= 1'b0;
      statShift_q <= 8'h00;
      startBlock_q <= 1'b0;
      startChip_q <= 1'b0;
      writeLatch_q <= 1'b0;
      spiMiso_q <= 1'b0;
      spiMisoOe_q <= 1'b0;
    end else begin
      startBlock_q <= 1'b0;
      startChip_q <= 1'b0;
      if (engDone) begin
        writeLatch_q <= 1'b0; // R7 R11
      end
      if (!csLow) begin
        spiMisoOe_q <= 1'b0;
        state_q <= S_OP;
        bitCnt_q <= 5'h00;
        if (csRiseEv && addrDone_q && writeLatch_q && !engBusy) begin // R2
          if (isCmd(op_q, `OP_BLOCK_ERASE)) begin
            startBlock_q <= 1'b1;
          end else if (isCmd(op_q, `OP_CHIP_ERASE)) begin
            startChip_q <= 1'b1;
          end
        end
        addrDone_q <= 1'b0;
      end else begin
        case (state_q)
          S_OP: begin
            if (sckRise) begin
              shift_q <= shiftNext;
              bitCnt_q <= bitCnt_q + 5'h01;
              if (bitCnt_q == 5'h07) begin
                op_q <= shiftNext;
                bitCnt_q <= 5'h00;
                if (isCmd(shiftNext, `OP_READ_STATUS)) begin
                  state_q <= S_STAT;
                  statShift_q <= statusByte;
                end else if (engBusy) begin
                  state_q <= S_IGN; // R5 R10
                end else if (isCmd(shiftNext, `OP_SET_WRITE_LATCH)) begin
                  writeLatch_q <= 1'b1;
                  state_q <= S_IGN;
                end else if (isCmd(shiftNext, `OP_CLEAR_WRITE_LATCH)) begin
                  writeLatch_q <= 1'b0;
                  state_q <= S_IGN;
                end else if (isCmd(shiftNext, `OP_BLOCK_ERASE)) begin
                  state_q <= S_ADDR;
                end else if (isCmd(shiftNext, `OP_CHIP_ERASE)) begin
                  addrDone_q <= 1'b1;
                  state_q <= S_IGN;
                end else begin
                  state_q <= S_IGN;
                end
              end
            end
          end
          S_ADDR: begin
            if (sckRise) begin
              bitCnt_q <= bitCnt_q + 5'h01;
              if (bitCnt_q >= IDX_FIRST && bitCnt_q <= IDX_LAST) begin
                blkIdx_q <= {blkIdx_q[1:0], mosiSync_q[1]}; // R4 R12
              end
              if (bitCnt_q == ADDR_LAST) begin
                addrDone_q <= 1'b1;
                state_q <= S_IGN;
              end
            end
          end
          S_STAT: begin
            spiMisoOe_q <= 1'b1;
            if (sckFall) begin
              spiMiso_q <= statShift_q[7];
              statShift_q <= {statShift_q[6:0], 1'b0};
              bitCnt_q <= bitCnt_q + 5'h01;
              if (bitCnt_q == 5'h08) begin
                statShift_q <= {statusByte[6:0], 1'b0};
                spiMiso_q <= statusByte[7];
                bitCnt_q <= 5'h01;
              end
            end
          end
          S_IGN: begin
            if (sckRise) begin
              addrDone_q <= 1'b0;
            end
          end
          default: state_q <= S_OP;
        endcase
      end
    end
  end

  // =====================================================
  // Erase engine
  erase_array_model #(
    .NUM_BLOCKS(NUM_BLOCKS),
    .CHIP_CYCLES(CHIP_CYCLES),
    .BLOCK_CYCLES(BLOCK_CYCLES)
  ) u_engine (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .startBlock(startBlock_q),
    .startChip(startChip_q),
    .blockIdx(blkIdx_q),
    .protectMask(protSync2_q),
    .busy_q(engBusy),
    .erased_q(engErased),
    .doneP_q(engDone)
  );

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      eraseBusy_q <= 1'b0;
      blockErased_q <= {NUM_BLOCKS{1'b0}};
    end else begin
      eraseBusy_q <= engBusy; // R6
      blockErased_q <= engErased;
    end
  end
endmodule // block_and_chip_erase_sequencer

//--- verification/spi_host_model.sv
module spi_host_model (
  output logic spiSck,
  output logic spiCs_b,
  output logic spiMosi,
  input wire logic spiMiso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    spiSck = 1'b0;
    spiCs_b = 1'b1;
    spiMosi = 1'b0;
  end
  // ====================
  // Mode 0 frame, MSB first, clock still between frames
  task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    spiCs_b = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spiMosi = d[i];
      #200 spiSck = 1'b1;
      rx = {rx[6:0], spiMiso};
      #200 spiSck = 1'b0;
    end
    #200 spiCs_b = 1'b1;
    spiMosi = ~spiMosi;
    #400;
  endtask
endmodule // spi_host_model

//--- verification/block_and_chip_erase_checker.sv
module block_and_chip_erase_checker #(
  parameter NUM_BLOCKS = 8,
  parameter CHIP_CYCLES = 80000000,
  parameter BLOCK_CYCLES = 20000000
) (
  input wire sys_clk,
  input wire rst_b,
  input wire spiSck,
  input wire spiCs_b,
  input wire spiMosi,
  input wire [NUM_BLOCKS-1:0] protectMask,
  input wire spiMiso_q,
  input wire spiMisoOe_q,
  input wire eraseBusy_q,
  input wire writeLatch_q,
  input wire [NUM_BLOCKS-1:0] blockErased_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  int busyCnt_q;
  always @(posedge sys_clk) busyCnt_q <= (!rst_b || !eraseBusy_q) ? 0 : busyCnt_q + 1;
  // ====================
  // Erase timing and latch
  a_busy_needs_latch: assert property ($rose(eraseBusy_q) |-> writeLatch_q) else $error("busy no latch");
  a_latch_clears_end: assert property ($fell(eraseBusy_q) |-> ##[0:2] !writeLatch_q) else $error("latch kept");
  a_busy_min_len: assert property ($rose(eraseBusy_q) |-> eraseBusy_q [*8]) else $error("busy short");
  a_busy_exact_len: assert property ($fell(eraseBusy_q) |->
    busyCnt_q == BLOCK_CYCLES || busyCnt_q == CHIP_CYCLES) else $error("busy length");
  a_protect_kept: assert property (((blockErased_q & ~$past(blockErased_q)) & protectMask) == 0)
    else $error("locked block erased");
  a_erase_with_busy: assert property ($changed(blockErased_q) |->
    ($past(eraseBusy_q, 3) or ##[0:3] eraseBusy_q)) else $error("erase no busy");
  a_latch_rise_idle: assert property ($rose(writeLatch_q) |-> !eraseBusy_q) else $error("latch set busy");
  a_latch_hold_busy: assert property ($fell(writeLatch_q) |-> ##[0:3] !eraseBusy_q) else $error("latch drop");
endmodule // block_and_chip_erase_checker

//--- verification/block_and_chip_erase_sequencer_tb_top.sv
`include "erase_seq_consts.vh"
module block_and_chip_erase_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] protectMask = 8'h08;
  logic [7:0] expErased = 8'h00;
  logic [7:0] rx;
  logic [31:0] addr;
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 14643;
  wire spiSck, spiCs_b, spiMosi, spiMiso_q, spiMisoOe_q, eraseBusy_q, writeLatch_q;
  wire [7:0] blockErased_q;
  wire misoLine = spiMisoOe_q ? spiMiso_q : 1'b1;
  always #25 sys_clk = ~sys_clk;
  spi_host_model spi_host_model_i (.spiSck(spiSck), .spiCs_b(spiCs_b), .spiMosi(spiMosi), .spiMiso(misoLine));
  block_and_chip_erase_sequencer #(.NUM_BLOCKS(8), .CHIP_CYCLES(800), .BLOCK_CYCLES(400))
    block_and_chip_erase_sequencer_i (.sys_clk(sys_clk), .rst_b(rst_b), .spiSck(spiSck), .spiCs_b(spiCs_b),
    .spiMosi(spiMosi), .protectMask(protectMask), .spiMiso_q(spiMiso_q), .spiMisoOe_q(spiMisoOe_q),
    .eraseBusy_q(eraseBusy_q), .writeLatch_q(writeLatch_q), .blockErased_q(blockErased_q));
  // ====================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [31:0] d, input int n);
    spi_host_model_i.xfer(d, n, rx);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 2000 && eraseBusy_q !== 1'b0; i++) @(negedge sys_clk);
    check({7'h00, eraseBusy_q}, 8'h00);
  endtask
  task automatic reset_dut;
    rst_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic blk(input logic [2:0] b);
    addr = $random(seed);
    addr[18:16] = b;
    cmd(`OP_SET_WRITE_LATCH, 8);
    check({7'h00, writeLatch_q}, 8'h01);
    cmd({`OP_BLOCK_ERASE, addr[23:0]}, 32);
    if (!protectMask[b]) begin
      expErased[b] = 1'b1;
      cmd({`OP_READ_STATUS, 8'h00}, 16);
      check(rx, 8'h03);
      cmd(`OP_CLEAR_WRITE_LATCH, 8);
      check({7'h00, writeLatch_q}, 8'h01);
    end
    wait_idle();
    check(blockErased_q, expErased);
    check({7'h00, writeLatch_q}, 8'h00);
    cmd({`OP_READ_STATUS, 8'h00}, 16);
    check(rx, 8'h00);
  endtask
  // ====================
  // Main sequence
  initial begin
    reset_dut();
    cmd(`OP_SET_WRITE_LATCH, 8);
    cmd(`OP_CLEAR_WRITE_LATCH, 8);
    check({7'h00, writeLatch_q}, 8'h00);
    cmd({`OP_BLOCK_ERASE, 24'h01_0000}, 32);
    wait_idle();
    check(blockErased_q, 8'h00);
    for (int b = 0; b < 8; b++) blk(b[2:0]);
    reset_dut();
    check(blockErased_q, 8'h00);
    protectMask = $random(seed);
    expErased = ~protectMask;
    cmd(`OP_SET_WRITE_LATCH, 8);
    cmd(`OP_CHIP_ERASE, 8);
    cmd(`OP_CLEAR_WRITE_LATCH, 8);
    check({7'h00, writeLatch_q}, 8'h01);
    wait_idle();
    check(blockErased_q, expErased);
    check({7'h00, writeLatch_q}, 8'h00);
    conclude();
  end
  initial begin
    #1_000_000;
    error_cnt++;
    conclude();
  end
endmodule // block_and_chip_erase_sequencer_tb_top
bind block_and_chip_erase_sequencer block_and_chip_erase_checker #(.NUM_BLOCKS(NUM_BLOCKS),
  .CHIP_CYCLES(CHIP_CYCLES), .BLOCK_CYCLES(BLOCK_CYCLES)) chk_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .spiSck(spiSck), .spiCs_b(spiCs_b), .spiMosi(spiMosi), .protectMask(protectMask), .spiMiso_q(spiMiso_q),
  .spiMisoOe_q(spiMisoOe_q), .eraseBusy_q(eraseBusy_q), .writeLatch_q(writeLatch_q),
  .blockErased_q(blockErased_q));
